// >>> emic_top.sv
// Purpose: digital-input control of event monitoring and per-parameter
//          waveform capture policy, behind a classic Wishbone slave.
// Assumes: inputs synchronous to clk after two-stage sync; 100 MHz clock.
// Notes:   capture edits land in a shadow copy until the commit command.
//
// Added by the designer: the Wishbone slave port and the placing of the registers.
`default_nettype none

// Notes on behaviour
// R1 - input 1 rising edge starts monitoring
// R2 - input 2 falling edge stops monitoring
// R3 - monitoring holds until the stop edge (code also ends it when a config write takes inputs 1/2 out of start/stop mode)
// R4 - snapshot edge on input 3/4 stores all channels
// R5 - start/stop and snapshot work at once
// R6 - inputs 1 and 2 configured as a pair
// R7 - every input defaults to unused, edges ignored
// R8 - capture plus all channels saves every channel
// R9 - capture alone saves only triggered channel
// R10 - both off saves no waveform
// R11 - refuse all-channels without capture, beep
// R12 - separate capture settings per threshold parameter
// R13 - threshold crossing event starts waveform saving
// R14 - capture settings default off for all parameters
// R15 - edits take effect only on exit commit
// R16 - inputs 3 and 4 set for snapshot independently
// R17 - sync inputs, compare samples, one pulse per edge
module emic_top (
   input  wire logic                                      clk,
   input  wire logic                                      reset,
   input  wire logic                                      wb_cyc_i,
   input  wire logic                                      wb_stb_i,
   input  wire logic                                      wb_we_i,
   input  wire logic [7:0]                                wb_adr_i,
   input  wire logic [3:0]                                wb_sel_i,
   input  wire logic [31:0]                               wb_dat_i,
   output logic      [31:0]                               wb_dat_o,
   output logic                                           wb_ack_o,
   input  wire logic [emic_pkg::EMIC_NUM_INPUTS-1:0]      dig_in,
   input  wire emic_pkg::emic_trig_t                      trig_i,
   output logic                                           monitor_active,
   output logic                                           digital_snapshot_event,
   output logic      [1:0]                                snapshot_src,
   output emic_pkg::emic_save_t                           wave_save,
   output logic                                           beep,
   output logic                                           irq
);

   localparam int unsigned NI = emic_pkg::EMIC_NUM_INPUTS;
   localparam int unsigned NP = emic_pkg::EMIC_NUM_PARAMS;
   localparam int unsigned NC = emic_pkg::EMIC_NUM_CHANS;
   localparam int unsigned IW = emic_pkg::EMIC_IRQ_W;
   localparam int unsigned PW = emic_pkg::EMIC_PIDX_W;

   // ---------------- input edge detection
   logic [NI-1:0] in_level;
   logic [NI-1:0] in_rise;
   logic [NI-1:0] in_fall;

   for (genvar i = 0; i < NI; i++) begin : g_in
      emic_edge u_edge (
         .clk   (clk),
         .reset (reset),
         .din   (dig_in[i]),
         .level (in_level[i]),
         .rise  (in_rise[i]),
         .fall  (in_fall[i])
      );
   end

   // ---------------- register state
   logic                   pair_ss_q;
   logic                   snap3_q;
   logic                   snap4_q;
   emic_pkg::emic_mon_t    mon_q;
   emic_pkg::emic_mon_t    mon_d;
   logic [IW-1:0]          stat_q;
   logic [IW-1:0]          stat_d;
   logic [IW-1:0]          mask_q;
   logic [NP-1:0]          st_wave_q;
   logic [NP-1:0]          st_all_q;
   logic [NP-1:0]          ed_wave_q;
   logic [NP-1:0]          ed_all_q;
   logic [PW-1:0]          idx_q;
   logic                   ack_q;
   logic [31:0]            dat_q;
   logic                   snap_q;
   logic [1:0]             snap_src_q;
   emic_pkg::emic_save_t   save_q;
   logic                   beep_q;
   logic                   irq_q;
   logic                   active_q;

   // ---------------- bus decode
   // ack high blocks a held request from being taken twice
   wire        bus_req   = wb_cyc_i & wb_stb_i & ~ack_q;
   wire        bus_wr    = bus_req & wb_we_i;
   wire [31:0] lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                            {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire        hit_cfg   = (wb_adr_i == emic_pkg::EMIC_ADR_CFG);
   wire        hit_stat  = (wb_adr_i == emic_pkg::EMIC_ADR_STATUS);
   wire        hit_istat = (wb_adr_i == emic_pkg::EMIC_ADR_IRQ_STAT);
   wire        hit_imask = (wb_adr_i == emic_pkg::EMIC_ADR_IRQ_MASK);
   wire        hit_capt  = (wb_adr_i == emic_pkg::EMIC_ADR_CAPT);
   wire        hit_cmd   = (wb_adr_i == emic_pkg::EMIC_ADR_EDIT_CMD);

   // ---------------- readback words
   wire [1:0] mode12 = pair_ss_q ? 2'(emic_pkg::EMIC_MODE_START_STOP)
                                 : 2'(emic_pkg::EMIC_MODE_UNUSED);
   wire [1:0] mode3  = snap3_q ? 2'(emic_pkg::EMIC_MODE_SNAPSHOT)
                               : 2'(emic_pkg::EMIC_MODE_UNUSED);
   wire [1:0] mode4  = snap4_q ? 2'(emic_pkg::EMIC_MODE_SNAPSHOT)
                               : 2'(emic_pkg::EMIC_MODE_UNUSED);

   logic [31:0] cfg_word;
   always_comb begin
      cfg_word = emic_pkg::EMIC_RD_ZERO;
      cfg_word[emic_pkg::EMIC_CFG_IN1_LSB +: 2] = mode12;   // R6
      cfg_word[emic_pkg::EMIC_CFG_IN2_LSB +: 2] = mode12;   // R6
      cfg_word[emic_pkg::EMIC_CFG_IN3_LSB +: 2] = mode3;
      cfg_word[emic_pkg::EMIC_CFG_IN4_LSB +: 2] = mode4;
   end

   // edits not yet committed
   wire        pending   = (ed_wave_q != st_wave_q) | (ed_all_q != st_all_q);
   logic [31:0] stat_word;
   always_comb begin
      stat_word = emic_pkg::EMIC_RD_ZERO;
      stat_word[emic_pkg::EMIC_ST_ACTIVE_BIT]      = (mon_q == emic_pkg::EMIC_MONITOR);
      stat_word[emic_pkg::EMIC_ST_PENDING_BIT]     = pending;
      stat_word[emic_pkg::EMIC_ST_LEVEL_LSB +: NI] = in_level;
   end

   logic [31:0] capt_word;
   always_comb begin
      capt_word = emic_pkg::EMIC_RD_ZERO;
      capt_word[emic_pkg::EMIC_CAPT_IDX_LSB +: PW] = idx_q;
      capt_word[emic_pkg::EMIC_CAPT_WAVE_BIT]      = ed_wave_q[idx_q];
      capt_word[emic_pkg::EMIC_CAPT_ALL_BIT]       = ed_all_q[idx_q];
      capt_word[emic_pkg::EMIC_CAPT_ST_WAVE_BIT]   = st_wave_q[idx_q];   // R15
      capt_word[emic_pkg::EMIC_CAPT_ST_ALL_BIT]    = st_all_q[idx_q];    // R15
   end

   wire [31:0] rd_word =
      hit_cfg   ? cfg_word :
      hit_stat  ? stat_word :
      hit_istat ? {26'h000_0000, stat_q} :
      hit_imask ? {26'h000_0000, mask_q} :
      hit_capt  ? capt_word :
                  emic_pkg::EMIC_RD_ZERO;

   // ---------------- config write with pairing
   wire [31:0] cfg_new = (cfg_word & ~lane_mask) | (wb_dat_i & lane_mask);
   wire [1:0]  new_m1  = cfg_new[emic_pkg::EMIC_CFG_IN1_LSB +: 2];
   wire [1:0]  new_m2  = cfg_new[emic_pkg::EMIC_CFG_IN2_LSB +: 2];
   wire [1:0]  new_m3  = cfg_new[emic_pkg::EMIC_CFG_IN3_LSB +: 2];
   wire [1:0]  new_m4  = cfg_new[emic_pkg::EMIC_CFG_IN4_LSB +: 2];
   // whichever half of the pair was changed decides for both
   wire [1:0]  pair_m  = (new_m1 != mode12) ? new_m1 : new_m2;   // R6
   wire        pair_d  =
      (pair_m == 2'(emic_pkg::EMIC_MODE_START_STOP)) ? 1'b1 :
      (pair_m == 2'(emic_pkg::EMIC_MODE_UNUSED))     ? 1'b0 : pair_ss_q;   // R6
   wire        snap3_d =
      (new_m3 == 2'(emic_pkg::EMIC_MODE_SNAPSHOT)) ? 1'b1 :
      (new_m3 == 2'(emic_pkg::EMIC_MODE_UNUSED))   ? 1'b0 : snap3_q;   // R16
   wire        snap4_d =
      (new_m4 == 2'(emic_pkg::EMIC_MODE_SNAPSHOT)) ? 1'b1 :
      (new_m4 == 2'(emic_pkg::EMIC_MODE_UNUSED))   ? 1'b0 : snap4_q;   // R16
   wire        cfg_we  = bus_wr & hit_cfg;

   // ---------------- capture-policy edit write
   wire [31:0]   capt_new  = (capt_word & ~lane_mask) | (wb_dat_i & lane_mask);
   wire [PW-1:0] capt_idx  = capt_new[emic_pkg::EMIC_CAPT_IDX_LSB +: PW];
   wire          capt_wave = capt_new[emic_pkg::EMIC_CAPT_WAVE_BIT];
   wire          capt_all  = capt_new[emic_pkg::EMIC_CAPT_ALL_BIT];
   wire          capt_we   = bus_wr & hit_capt & (capt_idx < PW'(NP));
   // a refused setting still moves the read index
   wire          capt_bad  = capt_we & ~capt_wave & capt_all;   // R11
   wire          capt_ok   = capt_we & ~capt_bad;
   wire          cmd_we    = bus_wr & hit_cmd & wb_sel_i[0];
   wire          commit    = cmd_we & wb_dat_i[emic_pkg::EMIC_CMD_COMMIT_BIT];
   // commit wins when both command bits are set
   wire          revert    = cmd_we & wb_dat_i[emic_pkg::EMIC_CMD_REVERT_BIT] & ~commit;

   // ---------------- monitoring control
   wire start_ev = pair_ss_q & in_rise[0];   // R1 R7
   wire stop_ev  = pair_ss_q & in_fall[1];   // R2 R7

   always_comb begin
      mon_d = mon_q;
      unique case (mon_q)
         emic_pkg::EMIC_IDLE: begin
            // start and stop together: stop wins
            if (start_ev && !stop_ev) begin
               mon_d = emic_pkg::EMIC_MONITOR;   // R1
            end
         end
         emic_pkg::EMIC_MONITOR: begin
            if (stop_ev) begin
               mon_d = emic_pkg::EMIC_IDLE;   // R2
            end
         end
      endcase
      // leaving start/stop mode ends any run in progress
      if (!pair_ss_q) begin
         mon_d = emic_pkg::EMIC_IDLE;
      end
   end

   // ---------------- snapshot, independent of start/stop
   wire snap3_ev = snap3_q & in_rise[2];   // R4 R5 R7
   wire snap4_ev = snap4_q & in_rise[3];   // R4 R5 R7

   // ---------------- waveform save on threshold crossing
   // an index beyond the table never saves
   wire          trig_hit  = trig_i.valid & (trig_i.param < PW'(NP));   // R13
   wire          trig_wave = trig_hit & st_wave_q[trig_i.param];        // R10 R12
   wire [NC-1:0] trig_one  = NC'(1) << trig_i.chan;
   wire [NC-1:0] trig_mask = st_all_q[trig_i.param] ? {NC{1'b1}}        // R8
                                                    : trig_one;         // R9

   // ---------------- interrupt status, set wins over clear
   wire [IW-1:0] ev_set;
   // start/stop bits only on a real state change
   assign ev_set[emic_pkg::EMIC_IRQ_START_BIT]  =
      start_ev & (mon_q == emic_pkg::EMIC_IDLE) & ~stop_ev;
   assign ev_set[emic_pkg::EMIC_IRQ_STOP_BIT]   =
      stop_ev & (mon_q == emic_pkg::EMIC_MONITOR);
   assign ev_set[emic_pkg::EMIC_IRQ_SNAP3_BIT]  = snap3_ev;
   assign ev_set[emic_pkg::EMIC_IRQ_SNAP4_BIT]  = snap4_ev;
   assign ev_set[emic_pkg::EMIC_IRQ_WAVE_BIT]   = trig_wave;
   assign ev_set[emic_pkg::EMIC_IRQ_REJECT_BIT] = capt_bad;

   wire [IW-1:0] stat_clr = (bus_wr & hit_istat) ? (wb_dat_i[IW-1:0] & lane_mask[IW-1:0])
                                                 : '0;
   assign stat_d = (stat_q & ~stat_clr) | ev_set;
   wire [IW-1:0] mask_new = (mask_q & ~lane_mask[IW-1:0]) | (wb_dat_i[IW-1:0] & lane_mask[IW-1:0]);

   // ---------------- bus slave flops
   always_ff @(posedge clk) begin
      if (reset) begin
         ack_q <= 1'b0;
         dat_q <= emic_pkg::EMIC_RD_ZERO;
      end else begin
         ack_q <= bus_req;
         if (bus_req && !wb_we_i) begin
            dat_q <= rd_word;
         end
      end
   end

   // ---------------- input configuration
   always_ff @(posedge clk) begin
      if (reset) begin
         pair_ss_q <= 1'b0;   // R7
         snap3_q   <= 1'b0;   // R7
         snap4_q   <= 1'b0;   // R7
      end else if (cfg_we) begin
         pair_ss_q <= pair_d;   // R6
         snap3_q   <= snap3_d;
         snap4_q   <= snap4_d;
      end
   end

   // output flop mirrors the state flop
   always_ff @(posedge clk) begin
      if (reset) begin
         mon_q    <= emic_pkg::EMIC_IDLE;
         active_q <= 1'b0;
      end else begin
         mon_q    <= mon_d;   // R3
         active_q <= (mon_d == emic_pkg::EMIC_MONITOR);   // R3
      end
   end

   // ---------------- interrupt registers
   always_ff @(posedge clk) begin
      if (reset) begin
         stat_q <= '0;
         mask_q <= emic_pkg::EMIC_IRQ_MASK_RST;
         irq_q  <= 1'b0;
      end else begin
         stat_q <= stat_d;
         if (bus_wr && hit_imask) begin
            mask_q <= mask_new;
         end
         // a mask written this cycle counts at once
         irq_q <= |(stat_d & ((bus_wr && hit_imask) ? mask_new : mask_q));
      end
   end

   // ---------------- capture policy: edit copy and committed copy
   always_ff @(posedge clk) begin
      if (reset) begin
         ed_wave_q <= emic_pkg::EMIC_CAPT_RST;   // R14
         ed_all_q  <= emic_pkg::EMIC_CAPT_RST;   // R14
         st_wave_q <= emic_pkg::EMIC_CAPT_RST;   // R14
         st_all_q  <= emic_pkg::EMIC_CAPT_RST;   // R14
         idx_q     <= '0;
      end else begin
         if (capt_we) begin
            idx_q <= capt_idx;
         end
         if (capt_ok) begin
            ed_wave_q[capt_idx] <= capt_wave;   // R12
            ed_all_q[capt_idx]  <= capt_all;    // R12
         end
         if (commit) begin
            st_wave_q <= ed_wave_q;   // R15
            st_all_q  <= ed_all_q;    // R15
         end
         if (revert) begin
            ed_wave_q <= st_wave_q;
            ed_all_q  <= st_all_q;
         end
      end
   end

   // ---------------- event outputs
   always_ff @(posedge clk) begin
      if (reset) begin
         snap_q     <= 1'b0;
         snap_src_q <= 2'h0;
         save_q     <= '0;
         beep_q     <= 1'b0;
      end else begin
         snap_q           <= snap3_ev | snap4_ev;   // R4 R5
         // both inputs may fire in one cycle
         snap_src_q       <= {snap4_ev, snap3_ev};
         save_q.valid     <= trig_wave;   // R13
         save_q.param     <= trig_i.param;
         // mask reads zero between saves
         save_q.chan_mask <= trig_wave ? trig_mask : '0;   // R8 R9 R10
         beep_q           <= capt_bad;   // R11
      end
   end

   assign wb_ack_o               = ack_q;
   assign wb_dat_o               = dat_q;
   assign monitor_active         = active_q;
   assign digital_snapshot_event = snap_q;
   assign snapshot_src           = snap_src_q;
   assign wave_save              = save_q;
   assign beep                   = beep_q;
   assign irq                    = irq_q;

endmodule : emic_top

`default_nettype wire

// >>> emic_pkg.sv
// Purpose: shared constants and types of the event monitor input control block,
//          plus the per-input synchroniser and edge detector.
// Assumes: single clock, synchronous active-high reset.
// Notes:   register offsets are byte addresses on a 32-bit Wishbone slave.
`default_nettype none

package emic_pkg;

   localparam int unsigned EMIC_NUM_INPUTS = 4;
   localparam int unsigned EMIC_NUM_PARAMS = 22;
   localparam int unsigned EMIC_PIDX_W     = 5;
   localparam int unsigned EMIC_NUM_CHANS  = 4;
   localparam int unsigned EMIC_CHAN_W     = 2;
   localparam int unsigned EMIC_IRQ_W      = 6;

   // register byte offsets
   localparam logic [7:0] EMIC_ADR_CFG      = 8'h00;
   localparam logic [7:0] EMIC_ADR_STATUS   = 8'h04;
   localparam logic [7:0] EMIC_ADR_IRQ_STAT = 8'h08;
   localparam logic [7:0] EMIC_ADR_IRQ_MASK = 8'h0C;
   localparam logic [7:0] EMIC_ADR_CAPT     = 8'h10;
   localparam logic [7:0] EMIC_ADR_EDIT_CMD = 8'h14;

   // config register: two-bit mode field per input
   localparam int unsigned EMIC_CFG_IN1_LSB = 0;
   localparam int unsigned EMIC_CFG_IN2_LSB = 2;
   localparam int unsigned EMIC_CFG_IN3_LSB = 4;
   localparam int unsigned EMIC_CFG_IN4_LSB = 6;

   // status register
   localparam int unsigned EMIC_ST_ACTIVE_BIT  = 0;
   localparam int unsigned EMIC_ST_PENDING_BIT = 1;
   localparam int unsigned EMIC_ST_LEVEL_LSB   = 4;

   // interrupt status / mask bits
   localparam int unsigned EMIC_IRQ_START_BIT  = 0;
   localparam int unsigned EMIC_IRQ_STOP_BIT   = 1;
   localparam int unsigned EMIC_IRQ_SNAP3_BIT  = 2;
   localparam int unsigned EMIC_IRQ_SNAP4_BIT  = 3;
   localparam int unsigned EMIC_IRQ_WAVE_BIT   = 4;
   localparam int unsigned EMIC_IRQ_REJECT_BIT = 5;

   // capture-policy edit register
   localparam int unsigned EMIC_CAPT_IDX_LSB      = 0;
   localparam int unsigned EMIC_CAPT_WAVE_BIT     = 8;
   localparam int unsigned EMIC_CAPT_ALL_BIT      = 9;
   localparam int unsigned EMIC_CAPT_ST_WAVE_BIT  = 16;
   localparam int unsigned EMIC_CAPT_ST_ALL_BIT   = 17;

   // edit command register
   localparam int unsigned EMIC_CMD_COMMIT_BIT = 0;
   localparam int unsigned EMIC_CMD_REVERT_BIT = 1;

   // reset values
   localparam logic [EMIC_IRQ_W-1:0]      EMIC_IRQ_MASK_RST = 6'h00;
   localparam logic [EMIC_NUM_PARAMS-1:0] EMIC_CAPT_RST     = 22'h00_0000;
   localparam logic [31:0]                EMIC_RD_ZERO      = 32'h0000_0000;

   // cycles after reset release before the edge detector trusts its samples
   localparam logic [1:0] EMIC_EDGE_PRIME = 2'h3;

   typedef enum logic [1:0] {
      EMIC_MODE_UNUSED,
      EMIC_MODE_START_STOP,
      EMIC_MODE_SNAPSHOT
   } emic_mode_t;

   typedef enum logic {
      EMIC_IDLE,
      EMIC_MONITOR
   } emic_mon_t;

   // threshold crossing raised by the measurement logic
   typedef struct packed {
      logic                   valid;
      logic [EMIC_PIDX_W-1:0] param;
      logic [EMIC_CHAN_W-1:0] chan;
   } emic_trig_t;

   // waveform save request toward the recorder
   typedef struct packed {
      logic                      valid;
      logic [EMIC_PIDX_W-1:0]    param;
      logic [EMIC_NUM_CHANS-1:0] chan_mask;
   } emic_save_t;

endpackage : emic_pkg

module emic_edge (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic din,
   output logic      level,
   output logic      rise,
   output logic      fall
);

   logic       meta_q;
   logic       sync_q;
   logic       prev_q;
   logic [1:0] prime_q;
   logic       primed;

   always_ff @(posedge clk) begin
      if (reset) begin
         meta_q  <= 1'b0;
         sync_q  <= 1'b0;
         prev_q  <= 1'b0;
         prime_q <= 2'h0;
      end else begin
         meta_q  <= din;
         sync_q  <= meta_q;
         prev_q  <= sync_q;
         if (!primed) begin
            prime_q <= prime_q + 2'h1;
         end
      end
   end

   // no false edge from a level already present at reset
   assign primed = (prime_q == emic_pkg::EMIC_EDGE_PRIME);
   assign level  = sync_q;
   assign rise   = primed & sync_q & ~prev_q;   // R17
   assign fall   = primed & ~sync_q & prev_q;   // R17

endmodule : emic_edge

`default_nettype wire

// >>> emic_top_props.sv
// Purpose: port-level checks of emic_top
// Assumes: one clock, synchronous active-high reset
// Notes:   bound into every emic_top
`default_nettype none
module emic_props (
   input wire logic                 clk,
   input wire logic                 reset,
   input wire logic                 wb_cyc_i,
   input wire logic                 wb_stb_i,
   input wire logic                 wb_ack_o,
   input wire logic [3:0]           dig_in,
   input wire emic_pkg::emic_trig_t trig_i,
   input wire logic                 monitor_active,
   input wire logic                 digital_snapshot_event,
   input wire logic [1:0]           snapshot_src,
   input wire emic_pkg::emic_save_t wave_save,
   input wire logic                 beep
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   property p_ack;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("ack not one cycle after request");
   property p_ack_once;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
   property p_start;
      $rose(monitor_active) |-> $past(dig_in[0], 3) && !$past(dig_in[0], 4);
   endproperty
   a_start: assert property (p_start) else $error("start without input 1 rise");
   property p_stop;
      $fell(monitor_active) |-> $past(wb_ack_o) || (!$past(dig_in[1], 3) && $past(dig_in[1], 4));
   endproperty
   a_stop: assert property (p_stop) else $error("stop without input 2 fall");
   property p_snap;
      $rose(digital_snapshot_event) |-> ($past(dig_in[2], 3) && !$past(dig_in[2], 4))
         || ($past(dig_in[3], 3) && !$past(dig_in[3], 4));
   endproperty
   a_snap: assert property (p_snap) else $error("snapshot without input rise");
   property p_src;
      digital_snapshot_event == (snapshot_src != 2'h0);
   endproperty
   a_src: assert property (p_src) else $error("snapshot source mismatch");
   property p_wave;
      wave_save.valid |-> $past(trig_i.valid) && wave_save.param == $past(trig_i.param);
   endproperty
   a_wave: assert property (p_wave) else $error("save without crossing");
   property p_mask;
      wave_save.valid |-> wave_save.chan_mask == 4'hF
         || wave_save.chan_mask == (4'h1 << $past(trig_i.chan));
   endproperty
   a_mask: assert property (p_mask) else $error("bad channel mask");
   property p_idle;
      !wave_save.valid |-> wave_save.chan_mask == 4'h0;
   endproperty
   a_idle: assert property (p_idle) else $error("mask without save");
   property p_beep;
      beep |-> wb_ack_o ##1 !beep;
   endproperty
   a_beep: assert property (p_beep) else $error("beep not tied to a write");
endmodule : emic_props
bind emic_top emic_props i_emic_props (
   .clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .dig_in(dig_in), .trig_i(trig_i),
   .monitor_active(monitor_active), .digital_snapshot_event(digital_snapshot_event),
   .snapshot_src(snapshot_src), .wave_save(wave_save), .beep(beep)
);
`default_nettype wire

// >>> emic_contacts.sv
// Purpose: external contacts driving the digital inputs
// Assumes: contacts change just after a clock edge
// Notes:   no bounce; level held until the next request
`default_nettype none
module emic_contacts (
   input  wire logic       clk,
   input  wire logic [3:0] close_req,
   output logic      [3:0] dig_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] lvl_q = 4'h0;
   always @(posedge clk) begin
      lvl_q <= close_req;
   end
   assign dig_in = lvl_q;
endmodule : emic_contacts
`default_nettype wire

// >>> tb_emic_top.sv
// Purpose: self-checking bench of emic_top
// Assumes: 100 MHz clock, reset held 5 cycles
// Notes:   contacts model drives dig_in, bench drives the bus
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module tb_emic_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic                 clk = 1'b0;
   logic                 reset = 1'b1;
   logic                 cyc = 1'b0;
   logic                 we = 1'b0;
   logic [7:0]           adr = 8'h00;
   logic [31:0]          wdat = 32'h0000_0000;
   logic [31:0]          rdat, dat_o;
   logic                 ack, mon, snap, beep, irq;
   logic [1:0]           src, last_src;
   logic [3:0]           close_req = 4'h0;
   logic [3:0]           dig_in, last_mask;
   emic_pkg::emic_trig_t trig = '0;
   emic_pkg::emic_save_t save;
   int                   n_mismatch = 0;
   int                   checks = 0;
   int                   n_snap = 0, n_save = 0, n_beep = 0;
   initial forever #5 clk = ~clk;
   emic_contacts i_emic_contacts (.clk(clk), .close_req(close_req), .dig_in(dig_in));
   emic_top i_emic_top (
      .clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .dig_in(dig_in), .trig_i(trig), .monitor_active(mon), .digital_snapshot_event(snap),
      .snapshot_src(src), .wave_save(save), .beep(beep), .irq(irq));
   always @(posedge clk) begin
      if (snap === 1'b1) begin n_snap++; last_src = src; end
      if (save.valid === 1'b1) begin n_save++; last_mask = save.chan_mask; end
      if (beep === 1'b1) n_beep++;
   end
   task automatic test_done();
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      cyc <= 1'b1; we <= w; adr <= a; wdat <= d;
      i = 0;
      do begin @(posedge clk); i++; end while (ack !== 1'b1 && i < 20);
      rdat = dat_o;
      cyc <= 1'b0;
      if (ack !== 1'b1) begin n_mismatch++; test_done(); end
   endtask : wb
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
      wb(1'b0, a, 32'h0000_0000);
      `CHK(n, e, rdat)
   endtask : rd
   task automatic wait_mon(input logic e);
      int i;
      for (i = 0; i < 12 && mon !== e; i++) @(posedge clk);
      `CHK("monitor_active", e, mon)
   endtask : wait_mon
   task automatic pulse_trig(input logic [4:0] p, input logic [1:0] c);
      @(posedge clk);
      trig <= '{1'b1, p, c};
      @(posedge clk);
      trig.valid <= 1'b0;
      tick(3);
   endtask : pulse_trig
   task automatic s_defaults();
      rd(8'h00, 32'h0000_0000, "cfg");
      wb(1'b1, 8'h10, 32'h0000_0000);
      rd(8'h10, 32'h0000_0000, "capt");
      rd(8'h0C, 32'h0000_0000, "mask");
      rd(8'h40, 32'h0000_0000, "unmapped");
      close_req <= 4'hF;
      tick(10);
      `CHK("mon unused", 1'b0, mon)
      `CHK("snap unused", 0, n_snap)
      close_req <= 4'h0;
      tick(8);
   endtask : s_defaults
   task automatic s_start_stop();
      wb(1'b1, 8'h00, 32'h0000_0004);
      rd(8'h00, 32'h0000_0005, "pair");
      close_req <= 4'h1;
      wait_mon(1'b1);
      close_req <= 4'h0;
      tick(8);
      `CHK("mon held", 1'b1, mon)
      close_req <= 4'h2;
      tick(8);
      `CHK("mon on rise 2", 1'b1, mon)
      close_req <= 4'h0;
      wait_mon(1'b0);
   endtask : s_start_stop
   task automatic s_snapshot();
      wb(1'b1, 8'h00, 32'h0000_0025);
      rd(8'h00, 32'h0000_0025, "cfg in3");
      close_req <= 4'h1;
      wait_mon(1'b1);
      close_req <= 4'h5;
      tick(8);
      `CHK("snap in3", 1, n_snap)
      `CHK("src in3", 2'h1, last_src)
      `CHK("mon beside snap", 1'b1, mon)
      close_req <= 4'hD;
      tick(8);
      `CHK("in4 unused", 1, n_snap)
      wb(1'b1, 8'h00, 32'h0000_00A5);
      close_req <= 4'h5;
      tick(2);
      close_req <= 4'hD;
      tick(8);
      `CHK("snap in4", 2, n_snap)
      `CHK("src in4", 2'h2, last_src)
      wb(1'b1, 8'h00, 32'h0000_00A0);
      tick(1);
      `CHK("leave pair", 1'b0, mon)
      rd(8'h00, 32'h0000_00A0, "pair off");
      close_req <= 4'h0;
   endtask : s_snapshot
   task automatic s_capture();
      wb(1'b1, 8'h10, 32'h0000_0103);
      pulse_trig(5'h03, 2'h2);
      `CHK("before commit", 0, n_save)
      rd(8'h10, 32'h0000_0103, "edit copy");
      wb(1'b1, 8'h14, 32'h0000_0001);
      pulse_trig(5'h03, 2'h2);
      `CHK("save one", 1, n_save)
      `CHK("mask one", 4'h4, last_mask)
      pulse_trig(5'h04, 2'h2);
      `CHK("other param", 1, n_save)
      wb(1'b1, 8'h10, 32'h0000_0303);
      wb(1'b1, 8'h14, 32'h0000_0001);
      pulse_trig(5'h03, 2'h1);
      `CHK("save all", 2, n_save)
      `CHK("mask all", 4'hF, last_mask)
      wb(1'b1, 8'h0C, 32'h0000_0020);
      wb(1'b1, 8'h10, 32'h0000_0203);
      tick(1);
      `CHK("beep", 1, n_beep)
      rd(8'h10, 32'h0003_0303, "refused");
      `CHK("irq up", 1'b1, irq)
      wb(1'b1, 8'h08, 32'h0000_0020);
      tick(2);
      `CHK("irq cleared", 1'b0, irq)
      wb(1'b1, 8'h10, 32'h0000_0003);
      wb(1'b1, 8'h14, 32'h0000_0001);
      pulse_trig(5'h03, 2'h0);
      `CHK("both off", 2, n_save)
   endtask : s_capture
   initial begin
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      s_defaults();
      s_start_stop();
      s_snapshot();
      s_capture();
      test_done();
   end
endmodule : tb_emic_top
`default_nettype wire
